// file: core/rx_irq_pkg.sv
// Constants and types for the receive interrupt mask bank
package rx_irq_pkg;
  // ****************************************************
  // Geometry
  // ****************************************************
  localparam int NUM_PORTS = 8;
  localparam int NUM_BANKS = 6;
  localparam int ADDR_W = 16;
  // ****************************************************
  // Register indices; byte address is four times index
  // ****************************************************
  localparam logic [11:0] PORT_STRIDE = 12'h200;
  localparam logic [8:0] IDX_ALARMS = 9'h0A0;
  localparam logic [8:0] IDX_E1_FRAMING = 9'h0A1;
  localparam logic [8:0] IDX_CODES = 9'h0A2;
  localparam logic [8:0] IDX_ELASTIC_TIMER = 9'h0A3;
  localparam logic [8:0] IDX_HDLC = 9'h0A4;
  localparam logic [8:0] IDX_BOC_FDL = 9'h0A6;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h0F0;
  localparam logic [11:0] IDX_IRQ_CLEAR = 12'h0F1;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'h0F2;
  localparam logic [11:0] IDX_LINE_MODE = 12'h0F3;
  // ****************************************************
  // Bank numbers and valid bits per line mode
  // ****************************************************
  localparam int B_ALARMS = 0;
  localparam int B_E1_FRAMING = 1;
  localparam int B_CODES = 2;
  localparam int B_ELASTIC_TIMER = 3;
  localparam int B_HDLC = 4;
  localparam int B_BOC_FDL = 5;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] VALID_ALARMS = 8'h0F;
  localparam logic [7:0] VALID_E1_FRAMING = 8'h0F;
  localparam logic [7:0] VALID_CODES_T1 = 8'hFF;
  localparam logic [7:0] VALID_CODES_E1 = 8'hBB;
  localparam logic [7:0] VALID_ELASTIC_TIMER = 8'hEF;
  localparam logic [7:0] VALID_HDLC = 8'h3F;
  localparam logic [7:0] VALID_BOC_FDL_T1 = 8'h3F;
  localparam logic [7:0] VALID_NONE = 8'h00;
  // Summary bit per bank, mirroring receive status register order
  localparam logic [2:0] SUM_BIT [NUM_BANKS] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  // ****************************************************
  // Carriers
  // ****************************************************
  typedef logic [NUM_BANKS-1:0][7:0] bank_type;
  typedef struct packed {
    logic [7:0] boc_fdl;
    logic [7:0] hdlc;
    logic [7:0] elastic_timer;
    logic [7:0] codes;
    logic [7:0] e1_framing;
    logic [7:0] alarms;
  } rx_status_type;
  typedef struct packed {
    logic [7:0] prdata;
    logic pslverr;
  } apb_answer_type;
endpackage

// file: core/rx_interrupt_mask_bank.sv
// Receive interrupt mask bank for eight framer ports with APB access
`timescale 1ns/100ps
`default_nettype none
module rx_interrupt_mask_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rx_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Latched receive status per port
  input wire rx_irq_pkg::rx_status_type [rx_irq_pkg::NUM_PORTS-1:0] rx_status,
  // Interrupt outputs
  output logic irq_out_n,
  output logic irq,
  output logic [rx_irq_pkg::NUM_PORTS-1:0][7:0] rx_irq_summary
);
  // ****************************************************
  // Reset release
  // ****************************************************
  // Assert at once, release two edges later, clear of the clock edge
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************************
  // Address fields
  // ****************************************************
  wire logic [1:0] byte_lane = paddr[1:0];
  wire logic [1:0] top_bits = paddr[15:14];
  wire logic [11:0] idx = paddr[13:2];
  // Port number minus one sits above the slot stride
  wire logic [2:0] port_sel = idx[11:9];
  wire logic [8:0] local_idx = idx[8:0];

  // Sub-word and out-of-range addresses are refused, not folded
  wire logic lane_ok = byte_lane == 2'h0;
  wire logic range_ok = top_bits == 2'h0;
  wire logic aligned = lane_ok && range_ok;

  // ****************************************************
  // Mask register hits, same slot in every port
  // ****************************************************
  wire logic hit_alarms = local_idx == rx_irq_pkg::IDX_ALARMS;
  wire logic hit_framing = local_idx == rx_irq_pkg::IDX_E1_FRAMING;
  wire logic hit_codes = local_idx == rx_irq_pkg::IDX_CODES;
  wire logic hit_elastic = local_idx == rx_irq_pkg::IDX_ELASTIC_TIMER;
  wire logic hit_hdlc = local_idx == rx_irq_pkg::IDX_HDLC;
  wire logic hit_boc = local_idx == rx_irq_pkg::IDX_BOC_FDL;
  // Port slot index selects one of the six mask banks
  wire logic [5:0] bank_hit = {hit_boc, hit_hdlc, hit_elastic, hit_codes, hit_framing,
    hit_alarms};
  wire logic any_bank = |bank_hit;
  wire logic hit_mask = aligned && any_bank;

  // ****************************************************
  // Global register hits, port 1 slot only
  // ****************************************************
  // Full index match, so no other port aliases these
  wire logic hit_status = aligned && (idx == rx_irq_pkg::IDX_IRQ_STATUS);
  wire logic hit_clear = aligned && (idx == rx_irq_pkg::IDX_IRQ_CLEAR);
  wire logic hit_enable = aligned && (idx == rx_irq_pkg::IDX_IRQ_ENABLE);
  wire logic hit_mode = aligned && (idx == rx_irq_pkg::IDX_LINE_MODE);
  wire logic mapped = hit_mask | hit_status | hit_clear | hit_enable | hit_mode;

  // ****************************************************
  // Write strobes
  // ****************************************************
  // Only the low lane carries data; other strobe bits are ignored
  wire logic in_access = psel && penable;
  wire logic lane0 = pstrb[0];
  // Writes land only on the completing access cycle
  wire logic wr_go = in_access && pready && pwrite && lane0;
  wire logic wr_mode = wr_go && hit_mode;
  wire logic wr_enable = wr_go && hit_enable;
  wire logic wr_clear = wr_go && hit_clear;

  wire logic [7:0] wr_byte = pwdata[7:0];

  // ****************************************************
  // Line mode, one bit per port
  // ****************************************************
  // Reset leaves every port in T1
  logic [7:0] line_mode;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_mode <= 8'h00;
    end else if (wr_mode) begin
      line_mode <= wr_byte;
    end
  end

  // ****************************************************
  // Controller interrupt enable
  // ****************************************************
  logic [7:0] irq_enable;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= 8'h00;
    end else if (wr_enable) begin
      irq_enable <= wr_byte;
    end
  end

  // ****************************************************
  // Sticky request status
  // ****************************************************
  logic [7:0] irq_status;
  logic [7:0] port_req;

  wire logic [7:0] clr_bits = wr_clear ? wr_byte : 8'h00;
  // Set wins over a clear in the same cycle, so no request is lost
  wire logic [7:0] kept_bits = irq_status & ~clr_bits;
  wire logic [7:0] next_irq_status = kept_bits | port_req;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 8'h00;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // ****************************************************
  // Per-port mask storage and request logic
  // ****************************************************
  logic [7:0][7:0] rd_port;
  logic [7:0][7:0] next_summary;
  genvar p;
  generate
    for (p = 0; p < rx_irq_pkg::NUM_PORTS; p++) begin : g_port
      rx_irq_pkg::bank_type mask;
      rx_irq_pkg::bank_type valid;
      rx_irq_pkg::bank_type live;
      // Status bytes line up with the mask banks
      wire rx_irq_pkg::bank_type stat = rx_irq_pkg::bank_type'(rx_status[p]);

      // ****************************************************
      // Port decode
      // ****************************************************
      wire logic e1 = line_mode[p];
      wire logic port_hit = port_sel == 3'(p);
      wire logic port_wr = wr_go && hit_mask && port_hit;

      // ****************************************************
      // Bits present in the current line mode
      // ****************************************************
      // Mode picks which bits exist; storage stays when mode flips
      always_comb begin
        valid = '0;
        valid[rx_irq_pkg::B_ALARMS] = rx_irq_pkg::VALID_ALARMS;
        valid[rx_irq_pkg::B_ELASTIC_TIMER] = rx_irq_pkg::VALID_ELASTIC_TIMER;
        valid[rx_irq_pkg::B_HDLC] = rx_irq_pkg::VALID_HDLC;
        case (e1)
          1'b1: begin
            valid[rx_irq_pkg::B_E1_FRAMING] = rx_irq_pkg::VALID_E1_FRAMING;
            valid[rx_irq_pkg::B_CODES] = rx_irq_pkg::VALID_CODES_E1;
            valid[rx_irq_pkg::B_BOC_FDL] = rx_irq_pkg::VALID_NONE;
          end
          default: begin
            valid[rx_irq_pkg::B_E1_FRAMING] = rx_irq_pkg::VALID_NONE;
            valid[rx_irq_pkg::B_CODES] = rx_irq_pkg::VALID_CODES_T1;
            valid[rx_irq_pkg::B_BOC_FDL] = rx_irq_pkg::VALID_BOC_FDL_T1;
          end
        endcase
      end

      // ****************************************************
      // Mask storage, one byte per bank
      // ****************************************************
      // Full byte is stored; the mode only hides bits
      genvar b;
      for (b = 0; b < rx_irq_pkg::NUM_BANKS; b++) begin : g_bank
        // One write strobe per bank
        wire logic bank_wr = port_wr && bank_hit[b];
        wire logic [7:0] bank_next = bank_wr ? wr_byte : mask[b];
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            mask[b] <= rx_irq_pkg::MASK_RESET;
          end else begin
            mask[b] <= bank_next;
          end
        end
        // Masked or absent bits never reach the request
        assign live[b] = stat[b] & mask[b] & valid[b];
      end

      // ****************************************************
      // Request, summary and readback
      // ****************************************************
      assign port_req[p] = |live;
      // Summary and readback both see only bits of the current mode
      always_comb begin
        next_summary[p] = 8'h00;
        rd_port[p] = 8'h00;
        for (int k = 0; k < rx_irq_pkg::NUM_BANKS; k++) begin
          next_summary[p][rx_irq_pkg::SUM_BIT[k]] = |live[k];
          if (bank_hit[k]) begin
            rd_port[p] = mask[k] & valid[k];
          end
        end
      end
    end
  endgenerate

  // ****************************************************
  // Read mux
  // ****************************************************
  // Clear register reads back zero
  wire logic [7:0] rd_status = hit_status ? irq_status : 8'h00;
  wire logic [7:0] rd_enable = hit_enable ? irq_enable : 8'h00;
  wire logic [7:0] rd_mode = hit_mode ? line_mode : 8'h00;

  // Global hits are one-hot, so an OR merges them without priority
  wire logic [7:0] rd_global = rd_status | rd_enable | rd_mode;
  wire logic [7:0] rd_mask = rd_port[port_sel];
  wire logic [7:0] rd_byte = hit_mask ? rd_mask : rd_global;

  // ****************************************************
  // APB answer
  // ****************************************************
  // Answer prepared in setup so access completes in its first cycle
  wire logic setup = psel && !penable;
  wire logic rd_setup = setup && !pwrite;
  wire rx_irq_pkg::apb_answer_type next_answer = '{prdata: rd_byte, pslverr: !mapped};
  // One-cycle pulse: zero wait states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Unmapped or misaligned: error, no effect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && next_answer.pslverr;
    end
  end

  // Read data is zero outside read answers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= {24'h000000, next_answer.prdata};
    end else begin
      prdata <= 32'h00000000;
    end
  end

  // ****************************************************
  // Active-low interrupt pin
  // ****************************************************
  // One cycle behind the status inputs
  wire logic any_req = |port_req;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= !any_req;
    end
  end

  // ****************************************************
  // Controller interrupt
  // ****************************************************
  // Level, not pulse; software clears the sticky bit
  wire logic [7:0] enabled_status = irq_status & irq_enable;
  wire logic irq_live = |enabled_status;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_live;
    end
  end

  // ****************************************************
  // Per-port summary
  // ****************************************************
  // Bits 5 and 7 have no bank and stay low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_irq_summary <= '0;
    end else begin
      rx_irq_summary <= next_summary;
    end
  end
endmodule // rx_interrupt_mask_bank
`default_nettype wire

// file: verification/status_source.sv
// Model of the framer logic that presents latched receive status
`timescale 1ns/100ps
`default_nettype none
module status_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Requested and presented status
  input wire rx_irq_pkg::rx_status_type [rx_irq_pkg::NUM_PORTS-1:0] next_status,
  output var rx_irq_pkg::rx_status_type [rx_irq_pkg::NUM_PORTS-1:0] rx_status
);
  // Registered so status never moves on the sampling edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rx_status <= '0;
    else rx_status <= next_status;
  end
endmodule // status_source
`default_nettype wire

// file: verification/mask_bank_sva.sv
// Checker for the APB answer, interrupt pin and summary outputs of the mask bank
`timescale 1ns/100ps
`default_nettype none
module mask_bank_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // Status and interrupts
  input wire rx_irq_pkg::rx_status_type [rx_irq_pkg::NUM_PORTS-1:0] rx_status,
  input wire logic irq_out_n,
  input wire logic [rx_irq_pkg::NUM_PORTS-1:0][7:0] rx_irq_summary
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence setup_s; psel && !penable; endsequence
  sequence quiet_s; rx_status == '0; endsequence
  a_zero_wait: assert property (setup_s ##1 penable |-> pready) else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == '0) else $error("stray read data");
  a_quiet_irq: assert property (quiet_s |=> irq_out_n) else $error("irq without status");
  a_quiet_sum: assert property (quiet_s |=> rx_irq_summary == '0) else $error("summary set");
  a_sum_spare: assert property ((rx_irq_summary & {8{8'hA0}}) == '0) else $error("spare set");
  a_irq_summary: assert property (!irq_out_n |-> rx_irq_summary != '0) else $error("no cause");
endmodule // mask_bank_sva
bind rx_interrupt_mask_bank mask_bank_sva chk_i (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .rx_status(rx_status), .irq_out_n(irq_out_n), .rx_irq_summary(rx_irq_summary));
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the receive interrupt mask bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq_out_n, irq, err;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [7:0][7:0] summary;
  rx_irq_pkg::rx_status_type [7:0] next_status = '0, rx_status;
  logic [11:0] idx [6] = '{12'h0A0, 12'h0A1, 12'h0A2, 12'h0A3, 12'h0A4, 12'h0A6};
  logic [7:0] t1v [6] = '{8'h0F, 8'h00, 8'hFF, 8'hEF, 8'h3F, 8'h3F};
  logic [7:0] e1v [6] = '{8'h0F, 8'h0F, 8'hBB, 8'hEF, 8'h3F, 8'h00};
  int bad_count = 0, cmp_count = 0;
  status_source src (.clk(clk), .rstn(rstn), .next_status(next_status), .rx_status(rx_status));
  rx_interrupt_mask_bank uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_status(rx_status), .irq_out_n(irq_out_n),
    .irq(irq), .rx_irq_summary(summary));
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [15:0] ad(input int p, input logic [11:0] i);
    return 16'((i + 12'h200 * (p - 1)) * 4);
  endfunction
  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; no wait-state count is assumed
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, 16'h03CC, m ? 8'h80 : 8'h00);
      for (int i = 0; i < 6; i++) begin
        xfer(1'b0, ad(8, idx[i]), 8'h00);
        if (m == 0) chk("reset mask", 32'h0, rd);
        xfer(1'b1, ad(8, idx[i]), 8'hFF);
        xfer(1'b0, ad(8, idx[i]), 8'h00);
        chk("mask", {24'h0, m ? e1v[i] : t1v[i]}, rd);
      end
    end
    xfer(1'b0, ad(1, 12'h0A0), 8'h00);
    chk("other port", 32'h0, rd);
    pstrb <= 4'hE;
    xfer(1'b1, ad(1, 12'h0A0), 8'hFF);
    pstrb <= 4'hF;
    xfer(1'b0, ad(1, 12'h0A0), 8'h00);
    chk("no strobe", 32'h0, rd);
    xfer(1'b0, ad(1, 12'h0A5), 8'h00);
    chk("unmapped", 32'h1, {31'h0, err});
    next_status[7].alarms <= 8'hF0;
    next_status[7].boc_fdl <= 8'hFF;
    settle();
    chk("absent bits", 32'h1, {31'h0, irq_out_n});
    next_status[7].alarms <= 8'h01;
    settle();
    chk("irq out", 32'h0, {31'h0, irq_out_n});
    chk("summary", 32'h01, {24'h0, summary[7]});
    xfer(1'b1, 16'h03C8, 8'h80);
    settle();
    chk("irq", 32'h1, {31'h0, irq});
    xfer(1'b0, 16'h03C0, 8'h00);
    chk("irq status", 32'h80, rd);
    xfer(1'b1, ad(8, 12'h0A0), 8'h00);
    settle();
    chk("masked out", 32'h1, {31'h0, irq_out_n});
    chk("masked sum", 32'h0, {24'h0, summary[7]});
    xfer(1'b1, 16'h03C4, 8'h80);
    settle();
    chk("cleared", 32'h0, {31'h0, irq});
    results();
  end
endmodule // testbench
`default_nettype wire
